/* pkg/bsx_pkg.sv */
// shared constants of the bit, shift and stack execution block
package bsx_pkg;
    // bus word type
    typedef logic [31:0] bsx_word_t;
    typedef logic [31:0] bsx_addr_t;

    // register byte offsets (low 12 address bits)
    localparam logic [11:0] OFS_INSTR = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_STATUS_REGISTER = 12'h008;
    localparam logic [11:0] OFS_SP = 12'h00c;
    localparam logic [11:0] OFS_CFG = 12'h010;
    localparam logic [11:0] OFS_WDCNT = 12'h014;
    // windows selected by address bits 11:8, one word per byte
    localparam logic [3:0] WIN_GPR = 4'h1;
    localparam logic [3:0] WIN_IO = 4'h2;
    localparam logic [3:0] WIN_STK = 4'h3;

    // operation codes in instruction bits 15:11
    localparam logic [4:0] OP_IDLE = 5'h00;
    localparam logic [4:0] OP_PUSH = 5'h01;
    localparam logic [4:0] OP_POP = 5'h02;
    localparam logic [4:0] OP_LOGIC_LEFT_SHIFT = 5'h03;
    localparam logic [4:0] OP_LOGIC_RIGHT_SHIFT = 5'h04;
    localparam logic [4:0] OP_CARRY_LEFT_ROTATE = 5'h05;
    localparam logic [4:0] OP_CARRY_RIGHT_ROTATE = 5'h06;
    localparam logic [4:0] OP_ARITH_RIGHT_SHIFT = 5'h07;
    localparam logic [4:0] OP_SWAP = 5'h08;
    localparam logic [4:0] OP_FSET = 5'h09;
    localparam logic [4:0] OP_FCLR = 5'h0a;
    localparam logic [4:0] OP_IOSET = 5'h0b;
    localparam logic [4:0] OP_IOCLR = 5'h0c;
    localparam logic [4:0] OP_BIT_TO_TRANSFER = 5'h0d;
    localparam logic [4:0] OP_TRANSFER_TO_BIT = 5'h0e;
    localparam logic [4:0] OP_SLEEP = 5'h0f;
    localparam logic [4:0] OP_WATCHDOG_RESTART = 5'h10;
    localparam logic [4:0] OP_BREAK = 5'h11;
    localparam logic [4:0] OP_LAST = 5'h11;

    // instruction field positions
    localparam int OPC_LSB = 11;
    localparam int IDX_LSB = 6;
    localparam int BIT_LSB = 3;

    // status register flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;

    // configuration bits and the status word layout
    localparam int CFG_SRAM = 0;
    localparam int CFG_EXT = 1;
    localparam int CFG_WAIT_LSB = 4;
    localparam int STS_CYC_LSB = 8;
    localparam int STS_ILL = 16;

    // cycle counts
    localparam logic [4:0] CYC_ONE = 5'h01;
    localparam logic [4:0] CYC_PUSH = 5'h01;
    localparam logic [4:0] CYC_POP = 5'h02;
    localparam logic [4:0] CYC_SRAM_EXTRA = 5'h01;

    // reset values
    localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
endpackage : bsx_pkg

/* core/bsx_exec.sv */
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RQ1: push stores register, flags kept, one cycle
// RQ2: pop loads register, flags kept, two cycles
// RQ3: left shifts feed carry, update Z C N V H
// RQ4: right shifts feed carry, update Z C N V
// RQ5: io bit set or clear, no flags, one cycle
// RQ6: bit store copies register bit into transfer flag
// RQ7: bit load copies transfer flag into register bit
// RQ8: indexed one-cycle set and clear of each flag
// RQ9: sleep accepted in one cycle, flags kept
// RQ10: watchdog restart pulses, one cycle, flags kept
// RQ11: stack cycle counts stretch for external memory
// RQ12: internal sram stack access adds one cycle
// RQ13: nibble exchange swaps register halves, flags kept
// RQ14: idle operation takes one cycle, changes nothing
module bsx_exec #(
    parameter int STACK_DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hsel,
    input wire bsx_pkg::bsx_addr_t haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire bsx_pkg::bsx_word_t hwdata,
    input wire logic hready,
    output logic hreadyout,
    output bsx_pkg::bsx_word_t hrdata,
    output logic hresp,
    output logic watchdog_restart,
    output logic sleep_req
);
    import bsx_pkg::*;

    localparam int SPW = $clog2(STACK_DEPTH);

    typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_EXEC} bsx_state_t;

    // cycles an operation holds the bus, stretched by memory placement
    function automatic logic [4:0] op_cycles(input logic [4:0] op, input logic [7:0] cfg);
        logic [4:0] n;
        n = CYC_ONE;
        if (op == OP_PUSH) begin
            n = CYC_PUSH;
        end
        if (op == OP_POP) begin
            n = CYC_POP;
        end
        if (op == OP_PUSH || op == OP_POP) begin
            if (cfg[CFG_SRAM]) begin
                n = n + CYC_SRAM_EXTRA; // [RQ12]
            end
            if (cfg[CFG_EXT]) begin
                n = n + {1'b0, cfg[7:CFG_WAIT_LSB]}; // [RQ11]
            end
        end
        return n;
    endfunction : op_cycles

    // reset release synchroniser
    logic rst_q1_reg;
    logic rst_q2_reg;
    wire rst_n = rst_q2_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_q1_reg <= 1'b0;
            rst_q2_reg <= 1'b0;
        end else begin
            rst_q1_reg <= 1'b1;
            rst_q2_reg <= rst_q1_reg;
        end
    end

    // control and state
    bsx_state_t state_reg;
    logic [11:0] addr_reg; // latched address of the data phase
    logic wr_reg;
    logic map_reg; // upper address bits were zero
    logic [4:0] cnt_reg; // remaining execution cycles
    logic [7:0] status_register_reg; // status flags
    logic [SPW-1:0] sp_reg; // stack pointer, points at next free slot
    logic [7:0] cfg_reg;
    logic [15:0] instr_reg; // last instruction issued
    logic [4:0] lastcyc_reg;
    logic ill_reg; // sticky: unknown operation seen
    logic [15:0] wdcnt_reg;
    logic hready_reg;
    bsx_word_t hrdata_reg;
    logic watchdog_restart_reg;
    logic sleep_reg;

    // memories: register file, io space, stack
    logic [7:0] gpr_mem [32];
    logic [7:0] io_mem [32];
    logic [7:0] stk_mem [STACK_DEPTH];

    // address phase acceptance
    wire accept = hsel && htrans[1] && hready;
    wire in_data = (state_reg == ST_DATA);
    wire [3:0] win = addr_reg[11:8];
    wire [4:0] win_idx = addr_reg[6:2];
    wire bus_wr = in_data && wr_reg && map_reg;
    wire bus_rd = in_data && !wr_reg;

    // instruction decode; fields taken from the write data
    wire fire = bus_wr && (addr_reg == OFS_INSTR);
    wire [4:0] op = hwdata[OPC_LSB+4:OPC_LSB];
    wire [4:0] idx = hwdata[IDX_LSB+4:IDX_LSB];
    wire [2:0] bsel = hwdata[BIT_LSB+2:BIT_LSB];
    wire [7:0] rd_val = gpr_mem[idx];
    wire [4:0] cyc = op_cycles(op, cfg_reg);
    wire is_left = (op == OP_LOGIC_LEFT_SHIFT) || (op == OP_CARRY_LEFT_ROTATE);
    wire is_right = (op == OP_LOGIC_RIGHT_SHIFT) || (op == OP_CARRY_RIGHT_ROTATE)
        || (op == OP_ARITH_RIGHT_SHIFT);
    wire is_shift = is_left || is_right;
    wire [SPW-1:0] sp_up = sp_reg + 1'b1;
    wire [SPW-1:0] sp_dn = sp_reg - 1'b1;

    // shifter: rotate forms pull the old carry in
    wire c_old = status_register_reg[FLG_C];
    wire [7:0] sh_res = (op == OP_LOGIC_LEFT_SHIFT) ? {rd_val[6:0], 1'b0} : // [RQ3]
        (op == OP_CARRY_LEFT_ROTATE) ? {rd_val[6:0], c_old} : // [RQ3]
        (op == OP_LOGIC_RIGHT_SHIFT) ? {1'b0, rd_val[7:1]} : // [RQ4]
        (op == OP_CARRY_RIGHT_ROTATE) ? {c_old, rd_val[7:1]} : // [RQ4]
        {rd_val[7], rd_val[7:1]}; // [RQ4]
    wire sh_c = is_left ? rd_val[7] : rd_val[0];
    wire sh_n = sh_res[7];
    wire sh_v = sh_n ^ sh_c;
    wire sh_z = (sh_res == 8'h00);
    // half carry only follows the left forms; signed flag is left alone
    wire sh_h = is_left ? rd_val[3] : status_register_reg[FLG_H];
    wire [7:0] sh_status = {status_register_reg[7:6], sh_h, status_register_reg[FLG_S], sh_v,
        sh_n, sh_z, sh_c};

    // bit manipulation results
    wire [7:0] bit_mask = 8'h01 << bsel;
    wire [7:0] bit_load_res = status_register_reg[FLG_T] ? (rd_val | bit_mask) :
        (rd_val & ~bit_mask);
    wire [7:0] bit_store_status = rd_val[bsel] ? (status_register_reg | 8'h40) :
        (status_register_reg & 8'hbf);
    wire [7:0] swp_res = {rd_val[3:0], rd_val[7:4]};

    // register file write port
    wire gpr_we = (bus_wr && win == WIN_GPR) || (fire && (is_shift || op == OP_POP
        || op == OP_SWAP || op == OP_TRANSFER_TO_BIT));
    wire [4:0] gpr_wa = fire ? idx : win_idx;
    wire [7:0] gpr_wd = !fire ? hwdata[7:0] :
        is_shift ? sh_res : // [RQ3] [RQ4]
        (op == OP_POP) ? stk_mem[sp_up] : // [RQ2]
        (op == OP_SWAP) ? swp_res : // [RQ13]
        bit_load_res; // [RQ7]

    // io space write port
    wire io_we = (bus_wr && win == WIN_IO) || (fire && (op == OP_IOSET || op == OP_IOCLR));
    wire [7:0] io_wd = !fire ? hwdata[7:0] :
        (op == OP_IOSET) ? (io_mem[idx] | bit_mask) : // [RQ5]
        (io_mem[idx] & ~bit_mask); // [RQ5]

    // status register next value; only the ops that own flags touch it
    wire [7:0] status_register_next =
        (bus_wr && addr_reg == OFS_STATUS_REGISTER) ? hwdata[7:0] :
        !fire ? status_register_reg :
        is_shift ? sh_status : // [RQ3] [RQ4]
        (op == OP_FSET) ? (status_register_reg | bit_mask) : // [RQ8]
        (op == OP_FCLR) ? (status_register_reg & ~bit_mask) : // [RQ8]
        (op == OP_BIT_TO_TRANSFER) ? bit_store_status : // [RQ6]
        status_register_reg; // [RQ1] [RQ2] [RQ9] [RQ10] [RQ14]

    // read multiplexer
    wire [SPW-1:0] stk_idx = addr_reg[SPW+1:2];
    wire [7:0] win_byte = (win == WIN_GPR) ? gpr_mem[win_idx] :
        (win == WIN_IO) ? io_mem[win_idx] : stk_mem[stk_idx];
    wire is_win = (win == WIN_GPR) || (win == WIN_IO) || (win == WIN_STK);
    wire [31:0] status_word = {15'h0000, ill_reg, 3'h0, lastcyc_reg, 8'h00};
    wire [31:0] rd_word = !map_reg ? 32'h0000_0000 :
        (addr_reg == OFS_INSTR) ? {16'h0000, instr_reg} :
        (addr_reg == OFS_STATUS) ? status_word :
        (addr_reg == OFS_STATUS_REGISTER) ? {24'h000000, status_register_reg} :
        (addr_reg == OFS_SP) ? {{(32 - SPW){1'b0}}, sp_reg} :
        (addr_reg == OFS_CFG) ? {24'h000000, cfg_reg} :
        (addr_reg == OFS_WDCNT) ? {16'h0000, wdcnt_reg} :
        is_win ? {24'h000000, win_byte} : 32'h0000_0000;

    // memories carry no reset
    always_ff @(posedge clk_sys) begin
        if (gpr_we) begin
            gpr_mem[gpr_wa] <= gpr_wd;
        end
        if (io_we) begin
            io_mem[fire ? idx : win_idx] <= io_wd;
        end
        if (fire && op == OP_PUSH) begin
            stk_mem[sp_reg] <= rd_val; // [RQ1]
        end
    end

    // bus sequencer: each data phase holds hreadyout low for one cycle, an instruction write for the op's cycle count
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            addr_reg <= 12'h000;
            wr_reg <= 1'b0;
            map_reg <= 1'b0;
            cnt_reg <= 5'h00;
            hready_reg <= 1'b1;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        addr_reg <= haddr[11:0];
                        wr_reg <= hwrite;
                        map_reg <= (haddr[31:12] == 20'h00000);
                        hready_reg <= 1'b0;
                        state_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (bus_rd) begin
                        hrdata_reg <= rd_word;
                    end
                    // one-cycle ops release at once, stack ops wait out their count
                    if (fire && cyc > CYC_ONE) begin
                        cnt_reg <= cyc - CYC_ONE; // [RQ2] [RQ11] [RQ12]
                        state_reg <= ST_EXEC;
                    end else begin
                        hready_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_EXEC: begin
                    cnt_reg <= cnt_reg - 5'h01;
                    if (cnt_reg == 5'h01) begin
                        hready_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // architectural state updated by the operations and by software
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_register_reg <= STATUS_REGISTER_RST;
            sp_reg <= SPW'(STACK_DEPTH - 1);
            cfg_reg <= CFG_RST;
            instr_reg <= 16'h0000;
            lastcyc_reg <= 5'h00;
            ill_reg <= 1'b0;
            wdcnt_reg <= 16'h0000;
            watchdog_restart_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end else begin
            status_register_reg <= status_register_next;
            watchdog_restart_reg <= fire && (op == OP_WATCHDOG_RESTART); // [RQ10]
            sleep_reg <= fire && (op == OP_SLEEP); // [RQ9]
            if (bus_wr && addr_reg == OFS_CFG) begin
                cfg_reg <= hwdata[7:0];
            end
            if (bus_wr && addr_reg == OFS_SP) begin
                sp_reg <= hwdata[SPW-1:0];
            end
            // stack wraps silently; software must keep depth in range
            if (fire && op == OP_PUSH) begin
                sp_reg <= sp_dn; // [RQ1]
            end
            if (fire && op == OP_POP) begin
                sp_reg <= sp_up; // [RQ2]
            end
            if (fire) begin
                instr_reg <= hwdata[15:0];
                lastcyc_reg <= cyc;
            end
            if (fire && op == OP_WATCHDOG_RESTART) begin
                wdcnt_reg <= wdcnt_reg + 16'h0001;
            end
            // a new unknown op wins over the clearing write
            if (fire && op > OP_LAST) begin
                ill_reg <= 1'b1;
            end else if (bus_wr && addr_reg == OFS_STATUS && hwdata[STS_ILL]) begin
                ill_reg <= 1'b0;
            end
        end
    end

    // outputs straight from flops; response is always okay
    assign hreadyout = hready_reg;
    assign hrdata = hrdata_reg;
    assign hresp = 1'b0;
    assign watchdog_restart = watchdog_restart_reg;
    assign sleep_req = sleep_reg;

    // checks on the executed operations
    push_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ1]
        fire && op == OP_PUSH |=> status_register_reg == $past(status_register_reg))
        else $error("push altered status flags");
    pop_two_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ2]
        fire && op == OP_POP && cfg_reg[1:0] == 2'b00 |=> !hreadyout ##1 hreadyout)
        else $error("pop did not take two cycles");
    left_carry_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ3]
        fire && op == OP_LOGIC_LEFT_SHIFT |=> status_register_reg[FLG_C] == $past(rd_val[7])
        && status_register_reg[FLG_H] == $past(rd_val[3]))
        else $error("left shift carry or half carry wrong");
    arith_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ4]
        fire && op == OP_ARITH_RIGHT_SHIFT |=> gpr_mem[$past(idx)][7] == $past(rd_val[7])
        && status_register_reg[FLG_C] == $past(rd_val[0]))
        else $error("arithmetic shift lost sign or carry");
    io_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ5]
        fire && op == OP_IOSET |=> io_mem[$past(idx)][$past(bsel)]
        && status_register_reg == $past(status_register_reg))
        else $error("io bit set failed");
    transfer_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ6]
        fire && op == OP_BIT_TO_TRANSFER |=> status_register_reg[FLG_T] == $past(rd_val[bsel])
        && status_register_reg[5:0] == $past(status_register_reg[5:0]))
        else $error("bit store wrong");
    fset_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ8]
        fire && op == OP_FSET |=> status_register_reg[$past(bsel)] && hreadyout)
        else $error("indexed flag set failed");
    watchdog_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ10]
        fire && op == OP_WATCHDOG_RESTART |=> watchdog_restart && hreadyout
        ##1 !watchdog_restart)
        else $error("watchdog restart pulse wrong");
    sram_extra_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ12]
        fire && op == OP_PUSH && cfg_reg[1:0] == 2'b01 |=> !hreadyout ##1 hreadyout)
        else $error("sram push not stretched by one");
    idle_op_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ14]
        fire && op == OP_IDLE |=> hreadyout && $stable(status_register_reg)
        && $stable(sp_reg))
        else $error("idle operation changed state");
endmodule : bsx_exec
`default_nettype wire

/* tb/bsx_ahb_master.sv */
`timescale 1ns/100ps
`default_nettype none
// bus master stand-in: single whole-word transfers, one at a time
module bsx_ahb_master (
    input wire logic clk_sys,
    input wire logic hready,
    input wire bsx_pkg::bsx_word_t hrdata,
    output logic hsel,
    output bsx_pkg::bsx_addr_t haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output bsx_pkg::bsx_word_t hwdata
);
    import bsx_pkg::*;
    // quiet bus from time zero
    initial begin
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = '0;
    end
    // one transfer; waits counts data-phase edges up to the closing one
    task automatic xfer(input logic wr, input bsx_addr_t addr, input bsx_word_t wdat,
                        output bsx_word_t rdat, output int waits);
        waits = 0;
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        // address phase holds until hready is seen high
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'b00;
        // a read leaves no stale write value on the data lines
        hwdata <= wr ? wdat : ~hwdata;
        do begin
            @(posedge clk_sys);
            waits++;
        end while (hready !== 1'b1);
        rdat = hrdata;
        // released address lines change so nothing leans on old values
        hsel <= 1'b0;
        haddr <= ~addr;
    endtask : xfer
endmodule : bsx_ahb_master
`default_nettype wire

/* tb/bsx_exec_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("ERROR %s expected %h seen %h", what, exp, got); \
        end \
    end
module bsx_exec_tb;
    import bsx_pkg::*;
    localparam int DEPTH = 16; // small stack keeps the wrap point near
    localparam int LIMIT = 20000; // far above the roughly 850 cycles the tests take
    logic clk_sys;
    logic rst_b;
    logic hsel, hwrite, hready, hresp, watchdog_restart, sleep_req;
    logic [1:0] htrans;
    logic [2:0] hsize;
    bsx_addr_t haddr;
    bsx_word_t hwdata, hrdata;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int n_sleep = 0; // cycles seen with the sleep pulse high
    int n_watchdog = 0; // cycles seen with the watchdog pulse high
    // 10 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    bsx_exec #(.STACK_DEPTH(DEPTH)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .watchdog_restart(watchdog_restart), .sleep_req(sleep_req));
    bsx_ahb_master mst (.clk_sys(clk_sys), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // pulse counters and the hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (sleep_req === 1'b1) n_sleep++;
        if (watchdog_restart === 1'b1) n_watchdog++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic wr(input bsx_addr_t a, input bsx_word_t d);
        bsx_word_t r;
        int w;
        mst.xfer(1'b1, a, d, r, w);
    endtask : wr
    task automatic chk_rd(input string what, input bsx_addr_t a, input bsx_word_t e);
        bsx_word_t r;
        int w;
        mst.xfer(1'b0, a, '0, r, w);
        `CHK(what, e, r)
    endtask : chk_rd
    // executes one instruction; the bus stalls for its clock count
    task automatic run_op(input logic [4:0] op, input int idx, input int bt, input int n);
        bsx_word_t r;
        int w;
        mst.xfer(1'b1, 32'h0, {16'h0, op, idx[4:0], bt[2:0], 3'b000}, r, w);
        `CHK("op cycles", n + 1, w)
    endtask : run_op
    // expected register in 15:8 and flags in 7:0 after a shift
    function automatic logic [15:0] shift_exp(logic [4:0] op, logic [7:0] v, logic [7:0] s);
        logic [7:0] r;
        logic [7:0] f;
        f = s;
        f[FLG_C] = (op == OP_LOGIC_LEFT_SHIFT || op == OP_CARRY_LEFT_ROTATE) ? v[7] : v[0];
        case (op)
            OP_LOGIC_LEFT_SHIFT: r = {v[6:0], 1'b0};
            OP_CARRY_LEFT_ROTATE: r = {v[6:0], s[FLG_C]};
            OP_LOGIC_RIGHT_SHIFT: r = {1'b0, v[7:1]};
            OP_CARRY_RIGHT_ROTATE: r = {s[FLG_C], v[7:1]};
            default: r = {v[7], v[7:1]};
        endcase
        f[FLG_Z] = (r == 8'h00);
        f[FLG_N] = r[7];
        f[FLG_V] = r[7] ^ f[FLG_C];
        if (op == OP_LOGIC_LEFT_SHIFT || op == OP_CARRY_LEFT_ROTATE) f[FLG_H] = v[3];
        return {r, f};
    endfunction : shift_exp
    task automatic t_reset();
        chk_rd("flags", 32'h8, 32'h0);
        chk_rd("stack ptr", 32'hc, DEPTH - 1);
        chk_rd("unmapped", 32'h800, 32'h0);
        chk_rd("high addr", 32'h8000_0008, 32'h0);
        `CHK("hresp", 1'b0, hresp)
        $display("test reset done");
    endtask : t_reset
    task automatic t_shift();
        logic [4:0] ops [5] = '{OP_LOGIC_LEFT_SHIFT, OP_LOGIC_RIGHT_SHIFT, OP_CARRY_LEFT_ROTATE,
            OP_CARRY_RIGHT_ROTATE, OP_ARITH_RIGHT_SHIFT};
        logic [7:0] vals [3] = '{8'h81, 8'h48, 8'h80};
        logic [7:0] sr [3] = '{8'h51, 8'h50, 8'h00};
        logic [15:0] e;
        foreach (ops[i]) begin
            foreach (vals[k]) begin
                e = shift_exp(ops[i], vals[k], sr[k]);
                wr(32'h10c, {24'h0, vals[k]});
                wr(32'h8, {24'h0, sr[k]});
                run_op(ops[i], 3, 0, 1);
                chk_rd("shift result", 32'h10c, {24'h0, e[15:8]});
                chk_rd("shift flags", 32'h8, {24'h0, e[7:0]});
            end
        end
        $display("test shift done");
    endtask : t_shift
    task automatic t_flags();
        for (int i = 0; i < 8; i++) begin
            wr(32'h8, 32'h0);
            run_op(OP_FSET, 0, i, 1);
            chk_rd("flag set", 32'h8, 32'h1 << i);
            wr(32'h8, 32'hff);
            run_op(OP_FCLR, 0, i, 1);
            chk_rd("flag clear", 32'h8, 32'hff & ~(32'h1 << i));
        end
        $display("test flags done");
    endtask : t_flags
    task automatic t_bits();
        wr(32'h8, 32'h15);
        wr(32'h114, 32'h3c);
        wr(32'h118, 32'h0);
        wr(32'h21c, 32'h0f);
        run_op(OP_SWAP, 5, 0, 1);
        chk_rd("swap", 32'h114, 32'hc3);
        run_op(OP_IDLE, 5, 0, 1);
        chk_rd("idle reg", 32'h114, 32'hc3);
        chk_rd("swap flags", 32'h8, 32'h15);
        run_op(OP_BIT_TO_TRANSFER, 5, 0, 1);
        chk_rd("bit store", 32'h8, 32'h55);
        run_op(OP_TRANSFER_TO_BIT, 6, 4, 1);
        chk_rd("bit load", 32'h118, 32'h10);
        run_op(OP_IOSET, 7, 7, 1);
        chk_rd("io set", 32'h21c, 32'h8f);
        run_op(OP_IOCLR, 7, 0, 1);
        chk_rd("io clear", 32'h21c, 32'h8e);
        chk_rd("bit flags", 32'h8, 32'h55);
        $display("test bits done");
    endtask : t_bits
    task automatic t_stack();
        logic [7:0] cfgs [4] = '{8'h00, 8'h01, 8'h32, 8'h23};
        int x;
        foreach (cfgs[k]) begin
            x = cfgs[k][0] + (cfgs[k][1] ? cfgs[k][7:4] : 0);
            wr(32'h10, {24'h0, cfgs[k]});
            wr(32'h8, 32'h5a);
            wr(32'h104, 32'ha0 + k);
            run_op(OP_PUSH, 1, 0, 1 + x);
            chk_rd("push cycles", 32'h4, (1 + x) << 8);
            chk_rd("stack top", 32'h300 + 4 * (DEPTH - 1), 32'ha0 + k);
            chk_rd("sp after push", 32'hc, DEPTH - 2);
            run_op(OP_POP, 2, 0, 2 + x);
            chk_rd("pop cycles", 32'h4, (2 + x) << 8);
            chk_rd("pop value", 32'h108, 32'ha0 + k);
            chk_rd("sp after pop", 32'hc, DEPTH - 1);
            chk_rd("stack flags", 32'h8, 32'h5a);
        end
        wr(32'h10, 32'h0);
        $display("test stack done");
    endtask : t_stack
    task automatic t_ctl();
        wr(32'h8, 32'ha5);
        run_op(OP_SLEEP, 0, 0, 1);
        chk_rd("wd count", 32'h14, 32'h0);
        `CHK("sleep pulses", 1, n_sleep)
        run_op(OP_WATCHDOG_RESTART, 0, 0, 1);
        wr(32'h14, 32'h77);
        chk_rd("wd count", 32'h14, 32'h1);
        `CHK("wd pulses", 1, n_watchdog)
        `CHK("sleep pulses", 1, n_sleep)
        run_op(OP_BREAK, 0, 0, 1);
        chk_rd("ctl flags", 32'h8, 32'ha5);
        run_op(5'h1f, 0, 0, 1);
        chk_rd("unknown op", 32'h4, 32'h1_0100);
        wr(32'h4, 32'h1_0000);
        chk_rd("sticky clear", 32'h4, 32'h0100);
        $display("test control done");
    endtask : t_ctl
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // reset, then the scenarios in turn
    initial begin
        rst_b = 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_reset();
        t_shift();
        t_flags();
        t_bits();
        t_stack();
        t_ctl();
        complete_run();
    end
endmodule : bsx_exec_tb
`default_nettype wire
